// file: sbc_spi_pkg.sv
// Constants, types and field layouts of the serial command checker.
package sbc_spi_pkg;

  // ****************************************************
  // Frame layout and address map
  // ****************************************************
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_COUNT = 5'h10;
  localparam logic [4:0] ADDR_DONE_COUNT = 5'h06;
  localparam logic [6:0] CTRL_ADDR_LO = 7'h01;
  localparam logic [6:0] CTRL_ADDR_HI = 7'h1E;
  localparam logic [6:0] STAT_ADDR_LO = 7'h41;
  localparam logic [6:0] STAT_ADDR_HI = 7'h7E;
  localparam logic [6:0] MODE_CTRL_ADDR = 7'h01;
  localparam logic [6:0] WD_CTRL_ADDR = 7'h03;
  localparam logic [6:0] BUS_CTRL_ADDR = 7'h04;
  localparam logic [6:0] WAKE_CTRL_ONE_ADDR = 7'h06;
  localparam logic [6:0] WAKE_CTRL_TWO_ADDR = 7'h07;
  localparam logic [6:0] LS_CTRL_ADDR = 7'h0A;
  localparam logic [6:0] TIMER_ONE_ADDR = 7'h0C;
  localparam logic [6:0] TIMER_TWO_ADDR = 7'h0D;
  localparam logic [7:0][6:0] STAT_ADDRS = {7'h55, 7'h54, 7'h52, 7'h46,
                                            7'h44, 7'h43, 7'h42, 7'h41};
  localparam logic [2:0] DEVICE_STATUS_IDX = 3'h2;
  localparam int CMD_FAIL_BIT = 1;

  // ****************************************************
  // Control fields
  // ****************************************************
  localparam int MODE_REQ_LSB = 6;
  localparam logic [1:0] REQ_NORMAL = 2'h0;
  localparam logic [1:0] REQ_SLEEP = 2'h1;
  localparam logic [1:0] REQ_STOP = 2'h2;
  localparam logic [1:0] REQ_RESTART = 2'h3;
  localparam int WAKE_MEAS_BIT = 0;
  localparam int WAKE_SYNC_BIT = 1;
  localparam logic [7:0] WAKE_PIN_ONE_TWO = 8'h03;
  localparam int WAKE_FOUR_BIT = 3;
  localparam logic [7:0] WAKE_TIMER_BITS = 8'h30;
  localparam int TIMER_ON_LSB = 3;
  localparam int TIMER_SYNC_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [4:0] {
    MODE_INIT    = 5'b00001,
    MODE_NORMAL  = 5'b00010,
    MODE_STOP    = 5'b00100,
    MODE_SLEEP   = 5'b01000,
    MODE_RESTART = 5'b10000
  } mode_t;

  typedef struct packed {
    logic [7:0] data;
    logic access;
    logic [6:0] addr;
  } frame_t;

endpackage

// file: sbc_spi_command_checker.sv
// Serial command front end with frame and command checking.
`timescale 1ns/1ps
module sbc_spi_command_checker
  import sbc_spi_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial link pins
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en_n,
  // Device side
  input wire logic [7:0][7:0] status_event,
  input wire logic long_open_window,
  input wire logic wake_event,
  input wire logic restart_done,
  output mode_t mode,
  output logic [1:0] lowside_on
);

  // ****************************************************
  // Helpers
  // ****************************************************
  // status address decode
  function automatic logic [3:0] stat_lookup(input logic [6:0] a);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (STAT_ADDRS[i] == a) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic is_ctrl(input logic [6:0] a);
    return (a >= CTRL_ADDR_LO) && (a <= CTRL_ADDR_HI);
  endfunction

  // ****************************************************
  // Pin synchronisers and edge detection
  // ****************************************************
  logic [2:0] sclk_sync_q;
  logic [2:0] csn_sync_q;
  logic [1:0] sdi_sync_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_sync_q <= 3'h0;
      csn_sync_q <= 3'h7;
      sdi_sync_q <= 2'h0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], serial_clk};
      csn_sync_q <= {csn_sync_q[1:0], chip_select_n};
      sdi_sync_q <= {sdi_sync_q[0], serial_in};
    end
  end

  logic sclk_s;
  logic sclk_rise;
  logic sclk_fall;
  logic csn_fall;
  logic csn_rise;
  logic selected;
  assign sclk_s = sclk_sync_q[1];
  assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
  assign csn_fall = ~csn_sync_q[1] & csn_sync_q[2];
  assign csn_rise = csn_sync_q[1] & ~csn_sync_q[2];
  assign selected = ~csn_sync_q[1];

  // ****************************************************
  // Frame reception and error check
  // ****************************************************
  frame_t rx_q;
  frame_t rx_shift;
  logic [4:0] fall_cnt_q;
  logic [4:0] rise_cnt_q;
  logic edge_err_q;
  logic frame_err_q;
  logic err_now;
  logic frame_ok;

  assign rx_shift = {sdi_sync_q[1], rx_q[FRAME_BITS-1:1]};
  assign err_now = edge_err_q | sclk_s |
                   ((fall_cnt_q != 5'h00) && (fall_cnt_q != FRAME_COUNT));
  assign frame_ok = csn_rise & ~err_now & (fall_cnt_q == FRAME_COUNT);

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_q <= '0;
      fall_cnt_q <= 5'h00;
    end else if (csn_fall) begin
      fall_cnt_q <= 5'h00;
    end else if (selected && sclk_fall) begin
      rx_q <= rx_shift;
      if (fall_cnt_q != 5'h1F) begin
        fall_cnt_q <= fall_cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      edge_err_q <= 1'b0;
      frame_err_q <= 1'b0;
    end else if (csn_fall) begin
      edge_err_q <= sclk_s;
    end else if (csn_rise) begin
      frame_err_q <= err_now;
    end
  end

  // ****************************************************
  // Status and control registers
  // ****************************************************
  logic [7:0][7:0] stat_q;
  logic [7:0] ctrl_q [0:30];
  mode_t mode_q;
  logic [3:0] rd_stat;
  logic [3:0] clr_stat;
  logic [7:0] rd_data;
  logic [6:0] rd_addr;
  logic in_restart;
  logic clr_cmd;
  logic [7:0] summary;

  assign in_restart = (mode_q == MODE_RESTART);
  // Bits enter at the top, so after seven falls the address sits there.
  assign rd_addr = rx_shift[FRAME_BITS-1 -: 7];
  assign rd_stat = stat_lookup(rd_addr);
  assign clr_stat = stat_lookup(rx_q.addr);
  assign clr_cmd = frame_ok & rx_q.access & clr_stat[3] & ~in_restart;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      summary[i] = |stat_q[i];
    end
  end

  always_comb begin
    rd_data = 8'h00;
    if (rd_stat[3]) begin
      rd_data = stat_q[rd_stat[2:0]];
    end else if (rd_addr == MODE_CTRL_ADDR) begin
      unique case (mode_q)
        MODE_SLEEP: rd_data = {REQ_SLEEP, 6'h00};
        MODE_STOP: rd_data = {REQ_STOP, 6'h00};
        MODE_RESTART: rd_data = {REQ_RESTART, 6'h00};
        default: rd_data = {REQ_NORMAL, 6'h00};
      endcase
    end else if (is_ctrl(rd_addr)) begin
      rd_data = ctrl_q[rd_addr[4:0]];
    end
  end

  // ****************************************************
  // Command checking
  // ****************************************************
  logic wr_cmd;
  logic cmd_fail;
  logic go_restart;
  logic go_normal;
  logic go_stop;
  logic go_sleep;
  logic store;
  logic [1:0] req;
  logic [7:0] wake_one;
  logic [7:0] wake_two;
  logic [7:0] wake_srcs;
  logic timers_off;
  logic [2:0] on_time;

  assign req = rx_q.data[MODE_REQ_LSB +: 2];
  assign wake_one = ctrl_q[WAKE_CTRL_ONE_ADDR[4:0]];
  assign wake_two = ctrl_q[WAKE_CTRL_TWO_ADDR[4:0]];
  assign wake_srcs = wake_two | {7'h00, |ctrl_q[BUS_CTRL_ADDR[4:0]]} << 7;
  assign timers_off = (ctrl_q[TIMER_ONE_ADDR[4:0]][2:0] == 3'h0) &&
                      (ctrl_q[TIMER_TWO_ADDR[4:0]][2:0] == 3'h0);
  assign on_time = rx_q.data[TIMER_ON_LSB +: 3];
  assign wr_cmd = frame_ok & rx_q.access & is_ctrl(rx_q.addr) & ~in_restart;
  assign store = wr_cmd & ~cmd_fail & (rx_q.addr != MODE_CTRL_ADDR);

  always_comb begin
    cmd_fail = 1'b0;
    go_restart = 1'b0;
    go_normal = 1'b0;
    go_stop = 1'b0;
    go_sleep = 1'b0;
    if (wr_cmd) begin
      if (mode_q == MODE_STOP) begin
        if (rx_q.addr == MODE_CTRL_ADDR && req == REQ_NORMAL) begin
          go_normal = 1'b1;
        end else if (rx_q.addr == MODE_CTRL_ADDR && req == REQ_SLEEP) begin
          cmd_fail = 1'b1;
          go_restart = 1'b1;
        end else if (rx_q.addr != WD_CTRL_ADDR) begin
          cmd_fail = 1'b1;
        end
      end else if (rx_q.addr == MODE_CTRL_ADDR) begin
        if (mode_q == MODE_INIT && (req == REQ_STOP || req == REQ_SLEEP)) begin
          cmd_fail = 1'b1;
          go_normal = 1'b1;
        end else if (req == REQ_NORMAL) begin
          go_normal = 1'b1;
        end else if (req == REQ_RESTART) begin
          go_restart = 1'b1;
        end else if (req == REQ_STOP) begin
          go_stop = 1'b1;
        end else if (wake_srcs == 8'h00) begin
          cmd_fail = 1'b1;
          go_restart = 1'b1;
        end else if (wake_one[WAKE_MEAS_BIT] &&
                     (wake_srcs & ~WAKE_PIN_ONE_TWO) == 8'h00) begin
          cmd_fail = 1'b1;
          go_restart = 1'b1;
        end else if ((wake_srcs & ~WAKE_TIMER_BITS) == 8'h00 && timers_off) begin
          go_restart = 1'b1;
        end else begin
          go_sleep = 1'b1;
        end
      end else if (rx_q.addr == LS_CTRL_ADDR) begin
        cmd_fail = (rx_q.data[1:0] != 2'h0) & long_open_window;
      end else if (rx_q.addr == TIMER_ONE_ADDR ||
                   rx_q.addr == TIMER_TWO_ADDR) begin
        if (rx_q.data[TIMER_SYNC_BIT]) begin
          cmd_fail = ~wake_one[WAKE_SYNC_BIT];
        end else begin
          cmd_fail = (on_time >= rx_q.data[2:0]);
        end
      end else if (rx_q.addr == WAKE_CTRL_TWO_ADDR) begin
        cmd_fail = rx_q.data[WAKE_FOUR_BIT] & wake_one[WAKE_SYNC_BIT];
      end
    end
  end

  // ****************************************************
  // Register updates
  // ****************************************************
  // sticky status bits, set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      stat_q <= '0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (clr_cmd && clr_stat[2:0] == 3'(i)) begin
          stat_q[i] <= status_event[i];
        end else begin
          stat_q[i] <= stat_q[i] | status_event[i];
        end
      end
      if (cmd_fail) begin
        stat_q[DEVICE_STATUS_IDX][CMD_FAIL_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i <= 30; i++) begin
        ctrl_q[i] <= CTRL_RESET;
      end
    end else begin
      if (store) begin
        ctrl_q[rx_q.addr[4:0]] <= rx_q.data;
      end
      if (go_stop || go_sleep || go_restart) begin
        ctrl_q[LS_CTRL_ADDR[4:0]] <= CTRL_RESET;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= MODE_INIT;
    end else if (go_restart) begin
      mode_q <= MODE_RESTART;
    end else if (go_normal) begin
      mode_q <= MODE_NORMAL;
    end else if (go_stop) begin
      mode_q <= MODE_STOP;
    end else if (go_sleep) begin
      mode_q <= MODE_SLEEP;
    end else begin
      unique case (mode_q)
        MODE_INIT, MODE_NORMAL: mode_q <= mode_q;
        MODE_STOP: mode_q <= wake_event ? MODE_NORMAL : MODE_STOP;
        MODE_SLEEP: mode_q <= wake_event ? MODE_RESTART : MODE_SLEEP;
        MODE_RESTART: mode_q <= restart_done ? MODE_NORMAL : MODE_RESTART;
        default: mode_q <= MODE_RESTART;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lowside_on <= 2'h0;
    end else begin
      lowside_on <= (mode_q == MODE_NORMAL) ?
                    ctrl_q[LS_CTRL_ADDR[4:0]][1:0] : 2'h0;
    end
  end

  assign mode = mode_q;

  // ****************************************************
  // Serial answer
  // ****************************************************
  logic [7:0] summary_q;
  logic [7:0] rd_byte_q;
  logic [15:0] resp;
  assign resp = {rd_byte_q, summary_q};

  always_ff @(posedge clk) begin
    if (srst) begin
      summary_q <= 8'h00;
      rd_byte_q <= 8'h00;
    end else if (csn_fall) begin
      summary_q <= summary;
      rd_byte_q <= 8'h00;
    end else if (selected && sclk_fall && fall_cnt_q == ADDR_DONE_COUNT) begin
      rd_byte_q <= rd_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      serial_out <= 1'b0;
      serial_out_en_n <= 1'b1;
      rise_cnt_q <= 5'h00;
    end else if (csn_fall) begin
      serial_out <= frame_err_q;
      serial_out_en_n <= 1'b0;
      rise_cnt_q <= 5'h00;
    end else if (csn_rise) begin
      serial_out_en_n <= 1'b1;
    end else if (selected && sclk_rise && rise_cnt_q < FRAME_COUNT) begin
      serial_out <= resp[rise_cnt_q[3:0]];
      rise_cnt_q <= rise_cnt_q + 5'h01;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic fail_flag;
  assign fail_flag = stat_q[DEVICE_STATUS_IDX][CMD_FAIL_BIT];

  sequence s_frame_close;
    csn_rise;
  endsequence
  sequence s_mode_write(logic [1:0] r);
    s_frame_close ##0 (wr_cmd && rx_q.addr == MODE_CTRL_ADDR && req == r);
  endsequence

  property p_fail_discard;
    (cmd_fail && rx_q.addr == LS_CTRL_ADDR) |=>
      fail_flag && $stable(ctrl_q[LS_CTRL_ADDR[4:0]]);
  endproperty
  a_fail_discard: assert property (p_fail_discard)
    else $error("Rejected write changed a register.");

  property p_fail_sticky;
    $fell(fail_flag) |-> $past(clr_cmd && clr_stat[2:0] == DEVICE_STATUS_IDX);
  endproperty
  a_fail_sticky: assert property (p_fail_sticky)
    else $error("Fail flag cleared without a clear command.");

  property p_stop_sleep;
    (mode_q == MODE_STOP) ##0 s_mode_write(REQ_SLEEP) |=>
      mode_q == MODE_RESTART && fail_flag;
  endproperty
  a_stop_sleep: assert property (p_stop_sleep)
    else $error("Stop to sleep did not fail into restart.");

  property p_init_first;
    (mode_q == MODE_INIT) ##0 s_mode_write(REQ_STOP) |=>
      mode_q == MODE_NORMAL && fail_flag;
  endproperty
  a_init_first: assert property (p_init_first)
    else $error("First stop request did not land in normal.");

  property p_no_wake_sleep;
    (mode_q == MODE_NORMAL && wake_srcs == 8'h00) ##0
      s_mode_write(REQ_SLEEP) |=> mode_q == MODE_RESTART && fail_flag;
  endproperty
  a_no_wake_sleep: assert property (p_no_wake_sleep)
    else $error("Sleep without wake source was accepted.");

  property p_err_first;
    csn_fall |=> !serial_out_en_n && serial_out == $past(frame_err_q);
  endproperty
  a_err_first: assert property (p_err_first)
    else $error("Error bit not presented at frame start.");

  property p_restart_ignore;
    (in_restart && csn_rise) |=> !$fell(fail_flag) && !$rose(mode_q[2]);
  endproperty
  a_restart_ignore: assert property (p_restart_ignore)
    else $error("Command acted on during restart.");

  property p_release;
    csn_rise |=> serial_out_en_n [*2];
  endproperty
  a_release: assert property (p_release)
    else $error("Data output not released at select rise.");

  property p_summary;
    csn_fall |=> summary_q[DEVICE_STATUS_IDX] == $past(|stat_q[DEVICE_STATUS_IDX]);
  endproperty
  a_summary: assert property (p_summary)
    else $error("Summary bit does not match status register.");

endmodule // sbc_spi_command_checker

// file: spi_host_model.sv
// Host microcontroller model that runs framed serial transfers.
`timescale 1ns/1ps
module spi_host_model (
  // Serial link pins
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_en_n
);
  localparam int HALF = 32;

  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end

  // ****************************************************
  // Frame transfer
  // ****************************************************
  // One frame of nclk clocks; hi keeps the clock high at both select edges.
  // error bit trusted here
  // The error bit is always trusted, as no fail-safe exit happens here.
  task automatic xfer(input logic [15:0] word, input int nclk,
                      input bit hi, output logic err,
                      output logic [15:0] rx);
    rx = 16'h0000;
    serial_clk = hi;
    #HALF;
    chip_select_n = 1'b0;
    #HALF;
    err = serial_out_en_n ? 1'bx : serial_out;
    for (int i = 0; i < nclk; i++) begin
      serial_in = word[i % 16];
      serial_clk = 1'b1;
      #HALF;
      if (i < 16) begin
        rx[i] = serial_out_en_n ? 1'bx : serial_out;
      end
      serial_clk = 1'b0;
      #HALF;
    end
    serial_clk = hi;
    #HALF;
    chip_select_n = 1'b1;
    #HALF;
    // The clock stops and the released data line no longer holds its value.
    serial_clk = 1'b0;
    serial_in = ~serial_in;
    #(4 * HALF);
  endtask
endmodule // spi_host_model

// file: sbc_spi_command_checker_bench.sv
// Self-checking bench for the serial command checker.
`timescale 1ns/1ps
module sbc_spi_command_checker_bench;
  import sbc_spi_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic serial_clk, chip_select_n, serial_in, serial_out, serial_out_en_n;
  logic [7:0][7:0] status_event = '0;
  logic long_open_window = 1'b0;
  logic wake_event = 1'b0;
  logic restart_done = 1'b0;
  mode_t mode;
  logic [1:0] lowside_on;
  logic err;
  logic [15:0] rx;
  int err_count = 0;
  int checked = 0;

  always #2 clk = ~clk;

  sbc_spi_command_checker sbc_spi_command_checker_i (
    .clk(clk), .srst(srst), .serial_clk(serial_clk),
    .chip_select_n(chip_select_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en_n(serial_out_en_n),
    .status_event(status_event), .long_open_window(long_open_window),
    .wake_event(wake_event), .restart_done(restart_done), .mode(mode),
    .lowside_on(lowside_on));

  spi_host_model spi_host_model_i (
    .serial_clk(serial_clk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_en_n(serial_out_en_n));

  // ****************************************************
  // Helpers
  // ****************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic frame(input logic [6:0] a, input logic acc,
                       input logic [7:0] d, input int n = 16,
                       input bit hi = 1'b0);
    frame_t f;
    f = '{data: d, access: acc, addr: a};
    spi_host_model_i.xfer(f, n, hi, err, rx);
  endtask

  task automatic set_mode(input logic [1:0] r);
    frame(MODE_CTRL_ADDR, 1'b1, {r, 6'h00});
  endtask

  // Reads and clears the device status byte.
  task automatic fail_is(input logic exp);
    frame(7'h43, 1'b1, 8'h00);
    chk(rx[15:8], {6'h00, exp, 1'b0});
  endtask

  // Pulses the wake input or the restart completion input.
  task automatic kick(input bit wk);
    @(posedge clk) #1;
    wake_event = wk;
    restart_done = !wk;
    @(posedge clk) #1;
    wake_event = 1'b0;
    restart_done = 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // ****************************************************
  // Tests
  // ****************************************************
  task automatic t_status;
    frame(7'h00, 1'b0, 8'h00, 0);
    chk(err, 1'b0);
    chk(serial_out_en_n, 1'b1);
    @(posedge clk) #1 status_event[0] = 8'h84;
    status_event[7] = 8'h01;
    @(posedge clk) #1 status_event = '0;
    frame(STAT_ADDR_LO, 1'b0, 8'h00);
    chk(rx, 16'h8481);
    frame(STAT_ADDR_LO, 1'b1, 8'h00);
    chk(rx[15:8], 8'h84);
    frame(STAT_ADDR_LO, 1'b0, 8'h00);
    chk(rx, 16'h0080);
    frame(7'h55, 1'b1, 8'h00);
    frame(7'h55, 1'b0, 8'h00);
    chk(rx, 16'h0000);
    $display("status test done");
  endtask

  task automatic t_init;
    chk(mode, MODE_INIT);
    set_mode(REQ_STOP);
    chk(mode, MODE_NORMAL);
    fail_is(1'b1);
    fail_is(1'b0);
    $display("init test done");
  endtask

  task automatic t_frame;
    for (int k = 0; k < 3; k++) begin
      frame(CTRL_ADDR_HI, 1'b1, 8'h5A, k == 0 ? 15 : (k == 1 ? 17 : 16),
            k == 2);
      frame(CTRL_ADDR_HI, 1'b0, 8'h00);
      chk(err, 1'b1);
      chk(rx[15:8], 8'h00);
    end
    frame(CTRL_ADDR_HI, 1'b1, 8'h5A);
    chk(rx[15:8], 8'h00);
    frame(CTRL_ADDR_HI, 1'b0, 8'h00);
    chk(err, 1'b0);
    chk(rx[15:8], 8'h5A);
    $display("frame test done");
  endtask

  task automatic t_stop;
    set_mode(REQ_STOP);
    chk(mode, MODE_STOP);
    fail_is(1'b0);
    frame(LS_CTRL_ADDR, 1'b1, 8'h01);
    fail_is(1'b1);
    frame(WD_CTRL_ADDR, 1'b1, 8'h01);
    fail_is(1'b0);
    set_mode(REQ_SLEEP);
    chk(mode, MODE_RESTART);
    frame(7'h10, 1'b1, 8'h77);
    kick(1'b0);
    chk(mode, MODE_NORMAL);
    fail_is(1'b1);
    frame(7'h10, 1'b0, 8'h00);
    chk(rx[15:8], 8'h00);
    $display("stop test done");
  endtask

  task automatic t_sleep;
    set_mode(REQ_SLEEP);
    chk(mode, MODE_RESTART);
    kick(1'b0);
    fail_is(1'b1);
    frame(WAKE_CTRL_TWO_ADDR, 1'b1, 8'h10);
    set_mode(REQ_SLEEP);
    chk(mode, MODE_RESTART);
    kick(1'b0);
    fail_is(1'b0);
    frame(WAKE_CTRL_ONE_ADDR, 1'b1, 8'h01);
    frame(WAKE_CTRL_TWO_ADDR, 1'b1, WAKE_PIN_ONE_TWO);
    set_mode(REQ_SLEEP);
    chk(mode, MODE_RESTART);
    kick(1'b0);
    fail_is(1'b1);
    frame(BUS_CTRL_ADDR, 1'b1, 8'h01);
    set_mode(REQ_SLEEP);
    chk(mode, MODE_SLEEP);
    kick(1'b1);
    kick(1'b0);
    chk(mode, MODE_NORMAL);
    $display("sleep test done");
  endtask

  task automatic t_cfg;
    @(posedge clk) #1 long_open_window = 1'b1;
    frame(LS_CTRL_ADDR, 1'b1, 8'h02);
    chk(lowside_on, 2'b00);
    fail_is(1'b1);
    @(posedge clk) #1 long_open_window = 1'b0;
    frame(LS_CTRL_ADDR, 1'b1, 8'h02);
    chk(lowside_on, 2'b10);
    frame(TIMER_ONE_ADDR, 1'b1, 8'h12);
    fail_is(1'b1);
    frame(TIMER_TWO_ADDR, 1'b1, 8'h4A);
    fail_is(1'b1);
    frame(TIMER_TWO_ADDR, 1'b0, 8'h00);
    chk(rx[15:8], 8'h00);
    frame(TIMER_ONE_ADDR, 1'b1, 8'h0A);
    frame(TIMER_ONE_ADDR, 1'b0, 8'h00);
    chk(rx[15:8], 8'h0A);
    fail_is(1'b0);
    frame(WAKE_CTRL_ONE_ADDR, 1'b1, 8'h02);
    frame(WAKE_CTRL_TWO_ADDR, 1'b1, 8'h08);
    fail_is(1'b1);
    $display("config test done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    t_status;
    t_init;
    t_frame;
    t_stop;
    t_sleep;
    t_cfg;
    summarize;
  end

  initial begin
    #200000;
    err_count++;
    summarize;
  end
endmodule // sbc_spi_command_checker_bench
